// ==== hdl/sslr_defs.svh ====
// Offsets, field positions, reset values and slot identifiers for the sense slot and limiter registers.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef SSLR_DEFS_SVH
`define SSLR_DEFS_SVH

// Register indices; the byte address is four times the index.
`define SSLR_IDX_P5       4'ha
`define SSLR_IDX_P6       4'hb
`define SSLR_IDX_VBAT     4'hc
`define SSLR_IDX_LIM1     4'hd

// Reset values of the registers.
`define SSLR_RST_P5       8'h07
`define SSLR_RST_P6       8'h07
`define SSLR_RST_VBAT     8'h00
`define SSLR_RST_LIM1     8'ha4

// Field positions inside the first limiter control register.
`define SSLR_SLOPE_HI     7
`define SSLR_SLOPE_LO     6
`define SSLR_INF_HI       5
`define SSLR_INF_LO       3
`define SSLR_TRACK_BIT    2
`define SSLR_MODE_HI      1
`define SSLR_MODE_LO      0

// Slot identifiers carried in the marker byte.
`define SSLR_ID_SLOT5     3'h5
`define SSLR_ID_SLOT6     3'h6

`endif

// ==== hdl/sslr_pkg.sv ====
// Types shared by the sense slot and limiter register block.
`default_nettype none

package sslr_pkg;

    // Slot content codes of the sense slot selectors.
    typedef enum logic [2:0] {
        SSLR_SNS_VOLT   = 3'h0,
        SSLR_SNS_CURR   = 3'h1,
        SSLR_SNS_VBAT   = 3'h2,
        SSLR_SNS_CTRL   = 3'h3,
        SSLR_SNS_ALT    = 3'h4,
        SSLR_SNS_STAT   = 3'h5,
        SSLR_SNS_MARK   = 3'h6,
        SSLR_SNS_BLANK  = 3'h7
    } sslr_sns_t;

    // Bus answer phase, Gray coded: wait, then one answer cycle.
    typedef enum logic {
        SSLR_BUS_WAIT   = 1'b0,
        SSLR_BUS_ANSWER = 1'b1
    } sslr_bus_t;

endpackage

`default_nettype wire

// ==== hdl/sslr_regs.sv ====
// Sense slot selectors, battery readout and battery tracking limiter control.
`timescale 1ns/1ns
`default_nettype none
`include "sslr_defs.svh"

module sslr_regs #(
    parameter logic [7:0] INF_TOP_CODE = 8'hc3,   // Battery code that equals 3.9 V.
    parameter logic [7:0] INF_STEP     = 8'h05    // Battery codes per 0.1 V step.
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [7:0]  vbat_code,
    input  wire logic        vbat_valid,
    input  wire logic [15:0] sense_volt,
    input  wire logic [15:0] sense_curr,
    input  wire logic [7:0]  status_byte,
    input  wire logic [7:0]  control_byte,
    input  wire logic        frame_sync,
    output logic [15:0]      slot5_word,
    output logic             slot5_wide,
    output logic [15:0]      slot6_word,
    output logic             slot6_wide,
    output logic [9:0]       lim_reduce,
    output logic             lim_engaged,
    output logic [1:0]       lim_mode
);
    import sslr_pkg::*;

    //--------------------------------------------------------------------------
    // Decode helpers
    //--------------------------------------------------------------------------

    // Word index of a byte address; the low two bits are ignored.
    function automatic logic [3:0] word_index(input logic [5:0] addr);
        word_index = addr[5:2];
    endfunction

    // Slot content for one selector code: wide flag and 16-bit word.
    // Eight-bit contents sit in the upper byte, the lower byte is zero.
    function automatic logic [16:0] slot_content(
        input sslr_sns_t   sel,
        input logic        alt,
        input logic [2:0]  id,
        input logic [15:0] volt,
        input logic [15:0] curr,
        input logic [7:0]  vbat,
        input logic [7:0]  stat,
        input logic [7:0]  ctrl
    );
        case (sel)
            SSLR_SNS_VOLT:  slot_content = {1'b1, volt};
            SSLR_SNS_CURR:  slot_content = {1'b1, curr};
            SSLR_SNS_VBAT:  slot_content = {1'b0, vbat, 8'h00};
            SSLR_SNS_CTRL:  slot_content = {1'b0, ctrl, 8'h00};
            SSLR_SNS_ALT:   slot_content = alt ? {1'b1, curr} : {1'b1, volt};
            SSLR_SNS_STAT:  slot_content = {1'b0, stat, 8'h00};
            SSLR_SNS_MARK:  slot_content = {1'b0, alt, 4'h0, id, 8'h00};
            default:        slot_content = 17'h00000;
        endcase
    endfunction

    //--------------------------------------------------------------------------
    // Register state
    //--------------------------------------------------------------------------

    sslr_sns_t   p5_q, p5_d;             // Fifth slot content select.
    sslr_sns_t   p6_q, p6_d;             // Sixth slot content select.
    logic [7:0]  vbat_q, vbat_d;         // Last battery voltage sample.
    logic [1:0]  slope_q, slope_d;       // Limiter ratio code.
    logic [2:0]  inf_q, inf_d;           // Battery inflection code.
    logic        track_q, track_d;       // Battery tracking enable.
    logic [1:0]  mode_q, mode_d;         // Limiter or mute mode.
    sslr_bus_t   bus_q, bus_d;           // Bus answer phase.
    logic [31:0] rdata_q, rdata_d;       // Read data held for the master.
    logic [3:0]  idx;                    // Word index of the request.
    logic        req;                    // A read or write is pending.
    logic        wr_take;                // Write takes effect this edge.

    assign idx     = word_index(avs_address);
    assign req     = avs_read | avs_write;
    assign wr_take = avs_write & (bus_q == SSLR_BUS_ANSWER) & avs_byteenable[0];

    // Next register values: writes land on the answer edge, reserved bits dropped.
    always_comb
    begin
        p5_d    = p5_q;
        p6_d    = p6_q;
        slope_d = slope_q;
        inf_d   = inf_q;
        track_d = track_q;
        mode_d  = mode_q;
        vbat_d  = vbat_valid ? vbat_code : vbat_q;
        if (wr_take && idx == `SSLR_IDX_P5)
        begin
            p5_d = sslr_sns_t'(avs_writedata[2:0]);
        end
        else if (wr_take && idx == `SSLR_IDX_P6)
        begin
            p6_d = sslr_sns_t'(avs_writedata[2:0]);
        end
        else if (wr_take && idx == `SSLR_IDX_LIM1)
        begin
            slope_d = avs_writedata[`SSLR_SLOPE_HI:`SSLR_SLOPE_LO];
            inf_d   = avs_writedata[`SSLR_INF_HI:`SSLR_INF_LO];
            track_d = avs_writedata[`SSLR_TRACK_BIT];
            mode_d  = avs_writedata[`SSLR_MODE_HI:`SSLR_MODE_LO];
        end
    end

    // Registers with their documented reset values.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            p5_q    <= sslr_sns_t'(3'(`SSLR_RST_P5));
            p6_q    <= sslr_sns_t'(3'(`SSLR_RST_P6));
            vbat_q  <= `SSLR_RST_VBAT;
            slope_q <= 2'(`SSLR_RST_LIM1 >> `SSLR_SLOPE_LO);
            inf_q   <= 3'(`SSLR_RST_LIM1 >> `SSLR_INF_LO);
            track_q <= 1'(`SSLR_RST_LIM1 >> `SSLR_TRACK_BIT);
            mode_q  <= 2'(`SSLR_RST_LIM1);
        end
        else
        begin
            p5_q    <= p5_d;
            p6_q    <= p6_d;
            vbat_q  <= vbat_d;
            slope_q <= slope_d;
            inf_q   <= inf_d;
            track_q <= track_d;
            mode_q  <= mode_d;
        end
    end

    //--------------------------------------------------------------------------
    // Avalon-MM slave
    //--------------------------------------------------------------------------

    // One wait cycle, then one answer cycle; unmapped reads return zero.
    always_comb
    begin
        bus_d   = SSLR_BUS_WAIT;
        rdata_d = rdata_q;
        if (req && bus_q == SSLR_BUS_WAIT)
        begin
            bus_d   = SSLR_BUS_ANSWER;
            rdata_d = 32'h00000000;
            if (idx == `SSLR_IDX_P5)
            begin
                rdata_d = {29'h0, p5_q};
            end
            else if (idx == `SSLR_IDX_P6)
            begin
                rdata_d = {29'h0, p6_q};
            end
            else if (idx == `SSLR_IDX_VBAT)
            begin
                rdata_d = {24'h0, vbat_q};
            end
            else if (idx == `SSLR_IDX_LIM1)
            begin
                rdata_d = {24'h0, slope_q, inf_q, track_q, mode_q};
            end
        end
    end

    // Registers the answer phase and read data.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_q   <= SSLR_BUS_WAIT;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            bus_q   <= bus_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest = (bus_q == SSLR_BUS_WAIT);
    assign avs_readdata    = rdata_q;

    //--------------------------------------------------------------------------
    // Sense slots
    //--------------------------------------------------------------------------

    logic        alt_q, alt_d;           // High in frames that carry current.
    logic [16:0] slot_q [2];             // Registered slot content per slot.
    logic [16:0] slot_d [2];             // Next slot content per slot.

    // Frame parity flips on each frame start.
    always_comb
    begin
        alt_d = frame_sync ? ~alt_q : alt_q;
    end

    // Content of slots five and six from their selectors.
    for (genvar s = 0; s < 2; s++)
    begin : g_slot
        always_comb
        begin
            slot_d[s] = slot_content((s == 0) ? p5_q : p6_q, alt_q,
                                     (s == 0) ? `SSLR_ID_SLOT5 : `SSLR_ID_SLOT6,
                                     sense_volt, sense_curr, vbat_q,
                                     status_byte, control_byte);
        end
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
            begin
                slot_q[s] <= 17'h00000;
            end
            else
            begin
                slot_q[s] <= slot_d[s];
            end
        end
    end

    // Registers the frame parity.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            alt_q <= 1'b0;
        end
        else
        begin
            alt_q <= alt_d;
        end
    end

    assign slot5_wide = slot_q[0][16];
    assign slot5_word = slot_q[0][15:0];
    assign slot6_wide = slot_q[1][16];
    assign slot6_word = slot_q[1][15:0];

    //--------------------------------------------------------------------------
    // Battery tracking threshold reduction
    //--------------------------------------------------------------------------

    logic [7:0] inf_level;               // Inflection level in battery codes.
    logic [7:0] deficit;                 // How far the battery sits below it.
    logic       below;                   // Battery is below the inflection.
    logic [9:0] reduce_q, reduce_d;      // Threshold reduction.
    logic       eng_q, eng_d;            // Reduction is active.
    logic [1:0] mode_out_q;              // Registered limiter mode output.

    assign inf_level = 8'(INF_TOP_CODE - 8'(inf_q * INF_STEP));
    assign below     = vbat_q < inf_level;
    assign deficit   = below ? 8'(inf_level - vbat_q) : 8'h00;

    // Reduction grows with the deficit times the ratio code; 1:1 gives none.
    always_comb
    begin
        reduce_d = 10'h000;
        eng_d    = 1'b0;
        if (track_q && below)
        begin
            reduce_d = 10'(deficit * slope_q);
            eng_d    = 1'b1;
        end
    end

    // Registers the limiter outputs.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reduce_q   <= 10'h000;
            eng_q      <= 1'b0;
            mode_out_q <= 2'h0;
        end
        else
        begin
            reduce_q   <= reduce_d;
            eng_q      <= eng_d;
            mode_out_q <= mode_q;
        end
    end

    assign lim_reduce  = reduce_q;
    assign lim_engaged = eng_q;
    assign lim_mode    = mode_out_q;

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_bus_answer: assert property (
        req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("Bus answer not one cycle after request.");
    a_p5_write: assert property (
        wr_take && idx == `SSLR_IDX_P5 |=> p5_q == $past(avs_writedata[2:0]))
        else $error("Fifth slot select write lost.");
    a_p6_write: assert property (
        wr_take && idx == `SSLR_IDX_P6 |=> p6_q == $past(avs_writedata[2:0]))
        else $error("Sixth slot select write lost.");
    a_resv_zero: assert property (
        !avs_waitrequest && (idx == `SSLR_IDX_P5 || idx == `SSLR_IDX_P6)
            |-> avs_readdata[31:3] == 29'h0)
        else $error("Reserved bits read non-zero.");
    a_vbat_ro: assert property (!vbat_valid |=> vbat_q == $past(vbat_q))
        else $error("Battery readout changed without a sample.");
    a_alt_slot: assert property (
        p5_q == SSLR_SNS_ALT |=> slot5_wide
            && slot5_word == ($past(alt_q) ? $past(sense_curr) : $past(sense_volt)))
        else $error("Alternating slot carried wrong word.");
    a_marker_byte: assert property (
        p6_q == SSLR_SNS_MARK
            |=> slot6_word == {$past(alt_q), 4'h0, `SSLR_ID_SLOT6, 8'h00})
        else $error("Marker byte wrong.");
    a_track_off: assert property (!track_q |=> lim_reduce == 10'h000 && !lim_engaged)
        else $error("Reduction active with tracking off.");
    a_reduce_val: assert property (
        track_q && below |=> lim_engaged
            && lim_reduce == 10'($past(deficit) * $past(slope_q)))
        else $error("Threshold reduction wrong.");

endmodule // sslr_regs
`default_nettype wire

// ==== tb/sslr_tdm_host.sv ====
// Audio host model that frames the TDM bus and counts the frames it has started.
`timescale 1ns/1ns
`default_nettype none

module sslr_tdm_host (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       frame_req,
    output logic            frame_sync,
    output logic [7:0]      frame_cnt
);
    // One frame start pulse per request; a frame is counted on the edge that sees its pulse.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            frame_sync <= 1'b0;
            frame_cnt  <= 8'h00;
        end
        else
        begin
            frame_sync <= frame_req;
            frame_cnt  <= frame_cnt + {7'h00, frame_sync};
        end
    end
endmodule // sslr_tdm_host
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the sense slot selectors and battery tracking limiter registers.
`timescale 1ns/1ns
`default_nettype none
`include "sslr_defs.svh"

module tb_top;
    localparam logic [7:0] INF_TOP = 8'hc3;  // Battery code at the top inflection step.
    localparam logic [7:0] INF_STP = 8'h05;  // Battery codes per inflection step.
    logic        sys_clk = 1'b0, rst = 1'b1;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0, avs_write = 1'b0, vbat_valid = 1'b0, frame_req = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, d;
    logic [3:0]  avs_byteenable = 4'hf;
    logic        avs_waitrequest, frame_sync, slot5_wide, slot6_wide, lim_engaged;
    logic [7:0]  vbat_code = 8'h00, status_byte = 8'h00, control_byte = 8'h00, frame_cnt;
    logic [15:0] sense_volt = 16'h0, sense_curr = 16'h0, slot5_word, slot6_word;
    logic [9:0]  lim_reduce;
    logic [1:0]  lim_mode;
    logic [7:0]  exp_vb = 8'h00, ctrl, v, lvl;
    integer      seed = 32'ha3af, n_errors = 0, total_checks = 0, cyc = 0;

    sslr_regs #(.INF_TOP_CODE(INF_TOP), .INF_STEP(INF_STP)) sslr_regs_inst (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .vbat_code(vbat_code), .vbat_valid(vbat_valid),
        .sense_volt(sense_volt), .sense_curr(sense_curr), .status_byte(status_byte),
        .control_byte(control_byte), .frame_sync(frame_sync), .slot5_word(slot5_word),
        .slot5_wide(slot5_wide), .slot6_word(slot6_word), .slot6_wide(slot6_wide),
        .lim_reduce(lim_reduce), .lim_engaged(lim_engaged), .lim_mode(lim_mode));

    sslr_tdm_host sslr_tdm_host_inst (
        .sys_clk(sys_clk), .rst(rst), .frame_req(frame_req),
        .frame_sync(frame_sync), .frame_cnt(frame_cnt));

    // Clock at 25 MHz.
    always #20 sys_clk = ~sys_clk;

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            n_errors = n_errors + 1;
            results();
        end
    end

    // Compares a seen value with the expected one.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One Avalon transfer; the request is held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        do
        begin
            @(posedge sys_clk);
            n = n + 1;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
            check("bus_answer", 32'h1, 32'h0);
    endtask

    // Reads a register and compares it.
    task automatic rd_chk(input string name, input logic [3:0] idx, input logic [31:0] exp);
        bus(1'b0, {idx, 2'b00}, 32'h0, 4'hf);
        check(name, rd, exp);
    endtask

    // Presents one battery sample for a single cycle.
    task automatic sample_vb(input logic [7:0] val);
        @(posedge sys_clk);
        vbat_code <= val;
        vbat_valid <= 1'b1;
        exp_vb = val;
        @(posedge sys_clk);
        vbat_valid <= 1'b0;
    endtask

    // Lets registered outputs settle, then stops mid cycle.
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // Fresh random sense data.
    task automatic new_sense();
        @(posedge sys_clk);
        d = $random(seed);
        sense_volt <= d[15:0];
        sense_curr <= d[31:16];
        d = $random(seed);
        status_byte <= d[7:0];
        control_byte <= d[15:8];
    endtask

    // Expected {wide, word} of a slot for a content code.
    function automatic logic [16:0] exp_slot(input logic [2:0] c, input logic p,
                                             input logic [2:0] id);
        case (c)
            3'h0: exp_slot = {1'b1, sense_volt};
            3'h1: exp_slot = {1'b1, sense_curr};
            3'h2: exp_slot = {1'b0, exp_vb, 8'h00};
            3'h3: exp_slot = {1'b0, control_byte, 8'h00};
            3'h4: exp_slot = {1'b1, p ? sense_curr : sense_volt};
            3'h5: exp_slot = {1'b0, status_byte, 8'h00};
            3'h6: exp_slot = {1'b0, p, 4'h0, id, 8'h00};
            default: exp_slot = 17'h0;
        endcase
    endfunction

    // Expected {engaged, reduction} for a control byte and battery code.
    function automatic logic [10:0] exp_lim(input logic [7:0] c, input logic [7:0] vb);
        logic [7:0] l;
        logic [9:0] r;
        l = INF_TOP - {5'h0, c[5:3]} * INF_STP;
        r = ({2'b0, l} - {2'b0, vb}) * {8'h0, c[7:6]};
        exp_lim = (c[2] && vb < l) ? {1'b1, r} : 11'h0;
    endfunction

    // Compares both slots with their selected contents.
    task automatic chk_slots(input logic [2:0] c5, input logic [2:0] c6);
        check("slot5", {15'h0, slot5_wide, slot5_word},
              {15'h0, exp_slot(c5, frame_cnt[0], `SSLR_ID_SLOT5)});
        check("slot6", {15'h0, slot6_wide, slot6_word},
              {15'h0, exp_slot(c6, frame_cnt[0], `SSLR_ID_SLOT6)});
    endtask

    // Main sequence.
    initial
    begin
        repeat (6) @(posedge sys_clk);
        check("wait_in_reset", {31'h0, avs_waitrequest}, 32'h1);
        rst <= 1'b0;
        rd_chk("slot5_rst", `SSLR_IDX_P5, {24'h0, `SSLR_RST_P5});
        rd_chk("slot6_rst", `SSLR_IDX_P6, {24'h0, `SSLR_RST_P6});
        rd_chk("vbat_rst", `SSLR_IDX_VBAT, {24'h0, `SSLR_RST_VBAT});
        rd_chk("lim_rst", `SSLR_IDX_LIM1, {24'h0, `SSLR_RST_LIM1});
        rd_chk("unmapped", 4'h0, 32'h0);
        check("lim_after_rst", {21'h0, lim_engaged, lim_reduce},
              {21'h0, exp_lim(`SSLR_RST_LIM1, `SSLR_RST_VBAT)});
        $display("test reset values done");
        for (int i = 0; i < 4; i++)
        begin
            d = $random(seed);
            bus(1'b1, {`SSLR_IDX_P5, 2'b00}, d, 4'hf);
            rd_chk("slot5_rw", `SSLR_IDX_P5, {29'h0, d[2:0]});
            bus(1'b1, {`SSLR_IDX_P5, 2'b00}, ~d, 4'he);
            rd_chk("slot5_lane", `SSLR_IDX_P5, {29'h0, d[2:0]});
            bus(1'b1, {`SSLR_IDX_P6, 2'b00}, d, 4'hf);
            rd_chk("slot6_rw", `SSLR_IDX_P6, {29'h0, d[2:0]});
            bus(1'b1, {`SSLR_IDX_LIM1, 2'b00}, d, 4'hf);
            rd_chk("lim_rw", `SSLR_IDX_LIM1, {24'h0, d[7:0]});
            bus(1'b1, {`SSLR_IDX_VBAT, 2'b00}, d, 4'hf);
            rd_chk("vbat_ro", `SSLR_IDX_VBAT, {24'h0, exp_vb});
            bus(1'b1, 6'h3c, d, 4'hf);
            rd_chk("unmapped_rw", 4'hf, 32'h0);
        end
        $display("test register access done");
        for (int c = 0; c < 8; c++)
        begin
            d = $random(seed);
            d[2:0] = c[2:0];
            bus(1'b1, {`SSLR_IDX_P5, 2'b00}, d, 4'hf);
            d[2:0] = ~c[2:0];
            bus(1'b1, {`SSLR_IDX_P6, 2'b00}, d, 4'hf);
            new_sense();
            d = $random(seed);
            sample_vb(d[7:0]);
            settle(2);
            chk_slots(c[2:0], ~c[2:0]);
        end
        $display("test slot codes done");
        bus(1'b1, {`SSLR_IDX_P5, 2'b00}, 32'h4, 4'hf);
        bus(1'b1, {`SSLR_IDX_P6, 2'b00}, 32'h6, 4'hf);
        for (int f = 0; f < 4; f++)
        begin
            new_sense();
            frame_req <= 1'b1;
            @(posedge sys_clk);
            frame_req <= 1'b0;
            settle(3);
            chk_slots(3'h4, 3'h6);
        end
        $display("test alternating frames done");
        for (int i = 0; i < 16; i++)
        begin
            d = $random(seed);
            ctrl = d[7:0];
            v = d[15:8];
            if (i < 4)
            begin
                ctrl = {i[1:0], 3'h4, 1'b1, i[1:0]};
                lvl = INF_TOP - 8'h04 * INF_STP;
                v = lvl - {7'h0, i[0]};
            end
            if (i == 4)
                ctrl[2] = 1'b0;
            bus(1'b1, {`SSLR_IDX_LIM1, 2'b00}, {24'h0, ctrl}, 4'hf);
            sample_vb(v);
            settle(3);
            check("lim", {21'h0, lim_engaged, lim_reduce},
                  {21'h0, exp_lim(ctrl, v)});
            check("lim_mode", {30'h0, lim_mode}, {30'h0, ctrl[1:0]});
            rd_chk("vbat_read", `SSLR_IDX_VBAT, {24'h0, v});
        end
        $display("test limiter tracking done");
        // A reset in mid-run must bring every written register back to its reset value.
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        exp_vb = `SSLR_RST_VBAT;
        rd_chk("slot5_rst2", `SSLR_IDX_P5, {24'h0, `SSLR_RST_P5});
        rd_chk("slot6_rst2", `SSLR_IDX_P6, {24'h0, `SSLR_RST_P6});
        rd_chk("vbat_rst2", `SSLR_IDX_VBAT, {24'h0, `SSLR_RST_VBAT});
        rd_chk("lim_rst2", `SSLR_IDX_LIM1, {24'h0, `SSLR_RST_LIM1});
        settle(1);
        check("mode_rst2", {30'h0, lim_mode}, 32'h0);
        $display("test mid-run reset done");
        results();
    end
endmodule // tb_top
`default_nettype wire
